// File: spsd_pkg.sv
// Constants, types and register map for the serial status and data port
// What this block does
// RULE1: Byte transfer end sets transfer_done_flag; interrupt if port_irq_enable set.
// RULE2: transfer_done_flag clears after status access then data register read or write.
// RULE3: While transfer_done_flag set, data writes ignored until status register read.
// RULE4: Data write during a transmit sequence sets read-only write_collision_flag.
// RULE5: Received byte arriving while transfer_done_flag set raises overrun_flag, and interrupt if enabled.
// RULE6: Reading the status register clears overrun_flag.
// RULE7: Select low while master sets master_fault_flag, interrupt if enabled.
// RULE8: master_fault_flag clears on status access while set, then control write.
// RULE9: Software keeps reserved status bit 3 written as zero.
// RULE10: output_disable stops the data output; otherwise drive only with port_enable.
// RULE11: select_soft_mode ignores the select pin, frees it, uses select_soft_level.
// RULE12: select_soft_level zero means selected, one means deselected.
// RULE13: As master, a data register write accepted while idle and not locked starts a new byte exchange.
// RULE14: At transfer end the shift register byte is copied into the receive buffer unless transfer_done_flag is already set.
// RULE15: Data register reads return the receive buffer, never the shift register.
// RULE16: Data register writes go straight into the shift register.
// RULE17: Interrupt while enable set and any of done, fault or overrun set.
// RULE18: Master fault clears port_enable and master_select.
// RULE19: Status register resets to zero, upper control bits to zero.
package spsd_pkg;
    localparam logic [7:0] ADDR_DATA  = 8'h21;
    localparam logic [7:0] ADDR_CTRL  = 8'h22;
    localparam logic [7:0] ADDR_CSR   = 8'h23;
    localparam logic [7:0] ADDR_EVT   = 8'h24;
    localparam logic [7:0] ADDR_MASK  = 8'h25;
    localparam int CTL_IRQ_EN = 7;
    localparam int CTL_PORT_EN = 6;
    localparam int CTL_MASTER = 4;
    localparam int CSR_DONE = 7;
    localparam int CSR_WRITE_COLLISION_FLAG = 6;
    localparam int CSR_OVR = 5;
    localparam int CSR_MASTER_FAULT_FLAG = 4;
    localparam int CSR_OD = 2;
    localparam int CSR_SSM = 1;
    localparam int CSR_SSI = 0;
    localparam int EVT_DONE = 0;
    localparam int EVT_WRITE_COLLISION_FLAG = 1;
    localparam int EVT_OVR = 2;
    localparam int EVT_MASTER_FAULT_FLAG = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [2:0] CSR_RESET = 3'h0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int SCK_HALF_DEFAULT = 2;
    // Pin inputs, bit order matches the synchroniser vector
    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ss_n;
    } spsd_pin_t;
endpackage : spsd_pkg

// File: spsd_port.sv
// Serial port status flags, select handling, data buffer and byte shifter
`timescale 1ns/1ns
module spsd_port #(
    parameter int SCK_HALF = spsd_pkg::SCK_HALF_DEFAULT
) (
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire logic [7:0]          addr,
    input  wire logic [7:0]          wdata,
    input  wire logic                wr,
    input  wire logic                rd,
    output logic      [7:0]          rdata,
    output logic                     irq,
    input  wire spsd_pkg::spsd_pin_t pins_in,
    output logic                     sck_out,
    output logic                     sck_oe_n,
    output logic                     mosi_out,
    output logic                     mosi_oe_n,
    output logic                     miso_out,
    output logic                     miso_oe_n,
    output logic                     ss_pin_free
);
    import spsd_pkg::*;

    logic [7:0] ctrl_reg;
    logic [2:0] csr_cfg_reg;
    logic       done_reg, write_collision_flag_reg, ovr_reg, master_fault_flag_reg;
    logic       csr_acc_reg, unlock_reg, master_fault_flag_arm_reg;
    logic [3:0] evt_reg, mask_reg;
    logic [7:0] shreg_reg, rxbuf_reg;
    logic [3:0] cnt_reg;
    logic       busy_reg, samp_reg, msck_reg, sck_prev_reg;
    logic [7:0] div_reg;
    logic [3:0] sy1_reg, sy2_reg, sy3_reg, pin_f_reg;

    logic wr_data, rd_data, wr_ctrl, acc_csr, rd_csr, data_acc;
    logic master, port_en, ss_int, sel, tick;
    logic rise_ev, fall_ev, xfer_done, master_fault_flag_ev, write_collision_flag_ev, ovr_ev;
    logic load_ok, start_ev, in_bit;

    assign wr_data  = wr && addr == ADDR_DATA;
    assign rd_data  = rd && addr == ADDR_DATA;
    assign wr_ctrl  = wr && addr == ADDR_CTRL;
    assign rd_csr   = rd && addr == ADDR_CSR;
    assign acc_csr  = (wr || rd) && addr == ADDR_CSR;
    assign data_acc = wr_data || rd_data;
    assign master   = ctrl_reg[CTL_MASTER];
    assign port_en  = ctrl_reg[CTL_PORT_EN];

    // Pins come from another domain; first stage feeds only the second
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sy1_reg <= 4'h1;
            sy2_reg <= 4'h1;
            sy3_reg <= 4'h1;
        end else begin
            sy1_reg <= pins_in;
            sy2_reg <= sy1_reg;
            sy3_reg <= sy2_reg;
        end
    end

    // A pin change counts only once two stages agree
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_f_reg <= 4'h1;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (sy2_reg[i] == sy3_reg[i]) begin
                    pin_f_reg[i] <= sy3_reg[i];
                end
            end
        end
    end

    assign ss_int = csr_cfg_reg[CSR_SSM] ? csr_cfg_reg[CSR_SSI] : pin_f_reg[0]; // [RULE11] [RULE12]
    assign sel    = port_en && !master && !ss_int; // [RULE12]

    // Master clock divider; only runs during a byte
    assign tick = busy_reg && master && div_reg == 8'(SCK_HALF - 1);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg  <= 8'h00;
            msck_reg <= 1'b0;
        end else if (!busy_reg || !master) begin
            div_reg  <= 8'h00;
            msck_reg <= 1'b0;
        end else if (tick) begin
            div_reg  <= 8'h00;
            msck_reg <= !msck_reg;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_prev_reg <= 1'b0;
        end else begin
            sck_prev_reg <= pin_f_reg[3];
        end
    end

    // Clock polarity and phase fixed at idle low, sample on rise
    assign rise_ev = master ? (tick && !msck_reg) : (sel && pin_f_reg[3] && !sck_prev_reg);
    assign fall_ev = master ? (tick && msck_reg) : (sel && !pin_f_reg[3] && sck_prev_reg);
    assign xfer_done = fall_ev && cnt_reg == BITS_PER_BYTE;

    // Writes locked while done is pending and status not yet read
    assign load_ok  = wr_data && !(done_reg && !unlock_reg) && !busy_reg; // [RULE3]
    assign write_collision_flag_ev  = wr_data && busy_reg; // [RULE4]
    assign start_ev = load_ok && master && port_en; // [RULE13]
    assign master_fault_flag_ev  = master && port_en && !ss_int; // [RULE7]
    assign ovr_ev   = xfer_done && done_reg; // [RULE5]

    // Synchroniser lag makes a master sample on the rise stale, so the master
    // Latches its input at the fall, just before the shift; needs SCK_HALF of 3 or more
    assign in_bit   = master ? pin_f_reg[1] : samp_reg;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_reg <= 1'b0;
            cnt_reg  <= 4'h0;
            samp_reg <= 1'b0;
        end else if (master_fault_flag_ev || !port_en) begin
            busy_reg <= 1'b0;
            cnt_reg  <= 4'h0;
        end else begin
            if (start_ev || (rise_ev && !master)) begin
                busy_reg <= 1'b1;
            end
            if (rise_ev) begin
                samp_reg <= pin_f_reg[2];
                cnt_reg  <= cnt_reg + 4'h1;
            end else if (xfer_done) begin
                busy_reg <= 1'b0;
                cnt_reg  <= 4'h0;
            end
        end
    end

    // No transmit buffer: the write lands in the shifter itself
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            shreg_reg <= 8'h00;
        end else if (load_ok) begin
            shreg_reg <= wdata; // [RULE16]
        end else if (fall_ev) begin
            shreg_reg <= {shreg_reg[6:0], in_bit};
        end
    end

    // On overrun the older byte is kept for software
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxbuf_reg <= 8'h00;
        end else if (xfer_done && !done_reg) begin
            rxbuf_reg <= {shreg_reg[6:0], in_bit}; // [RULE14]
        end
    end

    // Sequence trackers for the two-step clears
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            csr_acc_reg  <= 1'b0;
            unlock_reg   <= 1'b0;
            master_fault_flag_arm_reg <= 1'b0;
        end else begin
            if (acc_csr) begin
                csr_acc_reg <= 1'b1;
            end else if (data_acc) begin
                csr_acc_reg <= 1'b0;
            end
            if (xfer_done && !done_reg) begin
                unlock_reg <= 1'b0;
            end else if (rd_csr) begin
                unlock_reg <= 1'b1; // [RULE3]
            end
            if (acc_csr) begin
                master_fault_flag_arm_reg <= master_fault_flag_reg;
            end else if (wr_ctrl) begin
                master_fault_flag_arm_reg <= 1'b0;
            end
        end
    end

    // Status flags; a setting event always beats a clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_reg <= 1'b0;
            write_collision_flag_reg <= 1'b0;
            ovr_reg  <= 1'b0;
            master_fault_flag_reg <= 1'b0;
        end else begin
            if (xfer_done) begin
                done_reg <= 1'b1; // [RULE1]
            end else if (data_acc && csr_acc_reg) begin
                done_reg <= 1'b0; // [RULE2]
            end
            if (write_collision_flag_ev) begin
                write_collision_flag_reg <= 1'b1; // [RULE4]
            end else if (data_acc && csr_acc_reg) begin
                write_collision_flag_reg <= 1'b0;
            end
            if (ovr_ev) begin
                ovr_reg <= 1'b1; // [RULE5]
            end else if (rd_csr) begin
                ovr_reg <= 1'b0; // [RULE6]
            end
            if (master_fault_flag_ev) begin
                master_fault_flag_reg <= 1'b1; // [RULE7]
            end else if (wr_ctrl && master_fault_flag_arm_reg) begin
                master_fault_flag_reg <= 1'b0; // [RULE8]
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RESET; // [RULE19]
        end else if (master_fault_flag_ev) begin
            ctrl_reg[CTL_PORT_EN] <= 1'b0; // [RULE18]
            ctrl_reg[CTL_MASTER]  <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl_reg <= wdata;
        end
    end

    // Bit 3 is not stored, so a stray one cannot stick
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            csr_cfg_reg <= CSR_RESET; // [RULE19]
        end else if (wr && addr == ADDR_CSR) begin
            csr_cfg_reg <= wdata[2:0]; // [RULE9]
        end
    end

    // Sticky event copy, write one to clear, set wins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_reg  <= 4'h0;
            mask_reg <= 4'h0;
        end else begin
            evt_reg <= (evt_reg & ~((wr && addr == ADDR_EVT) ? wdata[3:0] : 4'h0))
                       | {master_fault_flag_ev, ovr_ev, write_collision_flag_ev, xfer_done};
            if (wr && addr == ADDR_MASK) begin
                mask_reg <= wdata[3:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= (ctrl_reg[CTL_IRQ_EN] && (done_reg || master_fault_flag_reg || ovr_reg)) // [RULE17] [RULE1] [RULE5] [RULE7]
                   || |(evt_reg & mask_reg);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (rd) begin
            unique case (addr)
                ADDR_DATA: rdata <= rxbuf_reg; // [RULE15]
                ADDR_CTRL: rdata <= ctrl_reg;
                ADDR_CSR:  rdata <= {done_reg, write_collision_flag_reg, ovr_reg, master_fault_flag_reg, 1'b0, csr_cfg_reg};
                ADDR_EVT:  rdata <= {4'h0, evt_reg};
                ADDR_MASK: rdata <= {4'h0, mask_reg};
                default:   rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // Pin drivers; enables are active low
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_out     <= 1'b0;
            sck_oe_n    <= 1'b1;
            mosi_out    <= 1'b0;
            mosi_oe_n   <= 1'b1;
            miso_out    <= 1'b0;
            miso_oe_n   <= 1'b1;
            ss_pin_free <= 1'b0;
        end else begin
            sck_out     <= msck_reg;
            sck_oe_n    <= !(port_en && master);
            mosi_out    <= shreg_reg[7];
            mosi_oe_n   <= !(port_en && master && !csr_cfg_reg[CSR_OD]); // [RULE10]
            miso_out    <= shreg_reg[7];
            miso_oe_n   <= !(sel && !csr_cfg_reg[CSR_OD]); // [RULE10]
            ss_pin_free <= csr_cfg_reg[CSR_SSM]; // [RULE11]
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    chk_done_sets: assert property (xfer_done |=> done_reg) // [RULE1]
        else $error("done flag not set after transfer");
    chk_done_clear: assert property ($fell(done_reg) |-> $past(data_acc) && $past(csr_acc_reg)) // [RULE2]
        else $error("done flag cleared without sequence");
    chk_lock_write: assert property (wr_data && done_reg && !unlock_reg && !fall_ev |=> $stable(shreg_reg)) // [RULE3]
        else $error("locked data write reached shifter");
    chk_write_collision_flag_set: assert property (wr_data && busy_reg |=> write_collision_flag_reg) // [RULE4]
        else $error("collision flag missed");
    chk_ovr_clear: assert property (rd_csr && !ovr_ev |=> !ovr_reg) // [RULE6]
        else $error("overrun not cleared by status read");
    chk_fault_ctrl: assert property (master_fault_flag_ev |=> !port_en && !master && master_fault_flag_reg) // [RULE7] [RULE18]
        else $error("fault did not disable port");
    chk_master_fault_flag_hold: assert property (master_fault_flag_reg && !(wr_ctrl && master_fault_flag_arm_reg) |=> master_fault_flag_reg) // [RULE8]
        else $error("fault flag cleared early");
    chk_od_pins: assert property (csr_cfg_reg[CSR_OD] |=> mosi_oe_n && miso_oe_n) // [RULE10]
        else $error("output driven while disabled");
    chk_irq_level: assert property (ctrl_reg[CTL_IRQ_EN] && ovr_reg |=> irq) // [RULE17]
        else $error("interrupt missing");
    chk_rx_copy: assert property (xfer_done && !done_reg |=> rxbuf_reg == $past({shreg_reg[6:0], in_bit})) // [RULE14]
        else $error("receive buffer not loaded");
    chk_ovr_keep: assert property (xfer_done && done_reg |=> ovr_reg && $stable(rxbuf_reg)) // [RULE5]
        else $error("overrun not flagged or buffer lost");
    chk_data_read: assert property (rd_data |=> rdata == $past(rxbuf_reg)) // [RULE15]
        else $error("data read not from receive buffer");
    chk_master_fault_flag_clear: assert property (wr_ctrl && master_fault_flag_arm_reg && !master_fault_flag_ev |=> !master_fault_flag_reg) // [RULE8]
        else $error("fault flag not cleared by sequence");
    chk_start_busy: assert property (start_ev && !master_fault_flag_ev |=> busy_reg) // [RULE13]
        else $error("master write did not start a byte");
    chk_pin_free: assert property (csr_cfg_reg[CSR_SSM] |=> ss_pin_free) // [RULE11]
        else $error("select pin not freed");
    chk_mosi_drive: assert property (port_en && master && !csr_cfg_reg[CSR_OD] |=> !mosi_oe_n) // [RULE10]
        else $error("master output not driven");
    chk_irq_off: assert property (!ctrl_reg[CTL_IRQ_EN] && !(|(evt_reg & mask_reg)) |=> !irq) // [RULE17]
        else $error("interrupt without cause");

    cov_master_byte: cover property (start_ev ##[1:200] xfer_done);
    cov_overrun: cover property (ovr_ev);
    cov_fault: cover property (master_fault_flag_ev);
    cov_slave_byte: cover property (xfer_done && !master);
    cov_collision: cover property (write_collision_flag_ev);
endmodule : spsd_port

// File: spsd_slave_model.sv
// Behavioural far-side serial slave for the port's master mode
`timescale 1ns/1ns
module spsd_slave_model (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic [7:0]      rx_byte
);
    logic [7:0] shift_reg;
    logic       last_bit;

    initial begin
        shift_reg = 8'h00;
        rx_byte   = 8'h00;
        last_bit  = 1'b0;
    end

    // Selection loads the reply byte, MSB presented first
    always @(negedge sel_n) begin
        shift_reg = tx_byte;
        last_bit  = tx_byte[7];
    end

    // Sample on rise, shift on fall
    always @(posedge sck) begin
        if (!sel_n) begin
            rx_byte = {rx_byte[6:0], mosi};
        end
    end

    always @(negedge sck) begin
        if (!sel_n) begin
            shift_reg = {shift_reg[6:0], 1'b0};
            last_bit  = shift_reg[7];
        end
    end

    // Released line shows the inverse, so a stale sample cannot pass
    assign miso = sel_n ? ~last_bit : shift_reg[7];
endmodule : spsd_slave_model

// File: testbench.sv
// Self-checking bench for the serial status and data port
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
    import spsd_pkg::*;
    logic       core_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       ext_sck = 1'b0;
    logic       ext_mosi = 1'b0;
    logic       ext_ss_n = 1'b1;
    logic       prt_sel_n = 1'b1;
    logic [7:0] prt_tx = 8'h00;
    logic [7:0] rdata, prt_rx;
    logic       irq, sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, ss_pin_free, prt_miso;
    logic       sck_w, mosi_w, miso_w;
    spsd_pin_t  pins_w;
    int         fail_count = 0;
    int         total_checks = 0;
    int         cycles = 0;

    always #25 core_clk = ~core_clk;

    // Pin levels resolved from the port's enables, else the far side drives
    assign sck_w  = !sck_oe_n ? sck_out : ext_sck;
    assign mosi_w = !mosi_oe_n ? mosi_out : ext_mosi;
    assign miso_w = !miso_oe_n ? miso_out : prt_miso;
    assign pins_w = {sck_w, mosi_w, miso_w, ext_ss_n};

    // Longer half period gives the 400 ns link clock
    spsd_port #(.SCK_HALF(4)) i_spsd_port (.core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .pins_in(pins_w), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
        .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_out(miso_out), .miso_oe_n(miso_oe_n),
        .ss_pin_free(ss_pin_free));

    spsd_slave_model i_spsd_slave_model (.sck(sck_w), .mosi(mosi_w), .sel_n(prt_sel_n), .tx_byte(prt_tx),
        .miso(prt_miso), .rx_byte(prt_rx));

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        @(negedge core_clk);
        `CHK(rdata, e)
    endtask : rd_chk

    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(irq, 1'b1)
    endtask : wait_irq

    task automatic settle;
        repeat (2) @(negedge core_clk);
    endtask : settle

    // Off-grid timing keeps link edges away from core clock edges
    task automatic slv_byte(input logic [7:0] d);
        #13;
        for (int i = 7; i >= 0; i--) begin
            ext_mosi = d[i];
            #200 ext_sck = 1'b1;
            #200 ext_sck = 1'b0;
        end
        ext_mosi = ~d[0];
        repeat (10) @(posedge core_clk);
    endtask : slv_byte

    task automatic t_reset;
        rd_chk(ADDR_CSR, 8'h00);
        rd_chk(ADDR_CTRL, 8'h00);
        rd_chk(8'h30, 8'h00);
        `CHK({sck_oe_n, mosi_oe_n, miso_oe_n, irq}, 4'b1110)
    endtask : t_reset

    task automatic t_master;
        prt_tx = 8'h5a;
        prt_sel_n = 1'b0;
        wr_reg(ADDR_CTRL, 8'hd0);
        wr_reg(ADDR_DATA, 8'ha5);
        settle();
        `CHK({sck_oe_n, mosi_oe_n, miso_oe_n}, 3'b001)
        wait_irq();
        wr_reg(ADDR_DATA, 8'h11);
        repeat (80) @(posedge core_clk);
        `CHK(prt_rx, 8'ha5)
        rd_chk(ADDR_CSR, 8'h80);
        prt_sel_n = 1'b1;
        prt_tx = 8'h3c;
        #1 prt_sel_n = 1'b0;
        wr_reg(ADDR_DATA, 8'h81);
        settle();
        `CHK(irq, 1'b0)
        wr_reg(ADDR_DATA, 8'h7e);
        wait_irq();
        rd_chk(ADDR_CSR, 8'hc0);
        rd_chk(ADDR_DATA, 8'h3c);
        `CHK(prt_rx, 8'h81)
        rd_chk(ADDR_CSR, 8'h00);
        wr_reg(ADDR_CSR, 8'h04);
        settle();
        `CHK({sck_oe_n, mosi_oe_n}, 2'b01)
        wr_reg(ADDR_CSR, 8'h00);
    endtask : t_master

    task automatic t_soft_fault;
        wr_reg(ADDR_CSR, 8'h03);
        ext_ss_n <= 1'b0;
        repeat (8) @(negedge core_clk);
        `CHK({ss_pin_free, irq}, 2'b10)
        rd_chk(ADDR_CSR, 8'h03);
        wr_reg(ADDR_CSR, 8'h02);
        repeat (4) @(negedge core_clk);
        `CHK(irq, 1'b1)
        rd_chk(ADDR_CTRL, 8'h80);
        rd_chk(ADDR_CSR, 8'h12);
        wr_reg(ADDR_CTRL, 8'h00);
        rd_chk(ADDR_CSR, 8'h02);
        ext_ss_n <= 1'b1;
        wr_reg(ADDR_CSR, 8'h00);
    endtask : t_soft_fault

    task automatic t_slave;
        prt_sel_n = 1'b1;
        wr_reg(ADDR_CTRL, 8'h40);
        wr_reg(ADDR_CSR, 8'h02);
        settle();
        `CHK({miso_oe_n, mosi_oe_n, sck_oe_n}, 3'b011)
        wr_reg(ADDR_DATA, 8'h96);
        settle();
        `CHK(miso_out, 1'b1)
        slv_byte(8'h3c);
        `CHK(irq, 1'b0)
        wr_reg(ADDR_MASK, 8'h01);
        settle();
        `CHK(irq, 1'b1)
        wr_reg(ADDR_EVT, 8'h01);
        settle();
        `CHK(irq, 1'b0)
        slv_byte(8'hc3);
        rd_chk(ADDR_CSR, 8'ha2);
        rd_chk(ADDR_CSR, 8'h82);
        rd_chk(ADDR_DATA, 8'h3c);
        rd_chk(ADDR_CSR, 8'h02);
    endtask : t_slave

    task automatic summarize;
        if (fail_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize

    // Whole run needs under 2000 cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fail_count++;
            summarize();
        end
    end

    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_reset();
        t_master();
        t_soft_fault();
        t_slave();
        summarize();
    end
endmodule : testbench
